// file: common/result_regs_pkg.sv
// Constants for the measurement result register bank
package result_regs_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_PRESS_HIGH = 8'h01;
	localparam logic [7:0] ADDR_PRESS_MID = 8'h02;
	localparam logic [7:0] ADDR_PRESS_LOW = 8'h03;
	localparam logic [7:0] ADDR_TEMP_HIGH = 8'h04;
	localparam logic [7:0] ADDR_TEMP_LOW = 8'h05;
	localparam logic [7:0] ADDR_CHANGE_HIGH = 8'h07;
	localparam logic [7:0] ADDR_CHANGE_MID = 8'h08;
	localparam logic [7:0] ADDR_CHANGE_LOW = 8'h09;
	localparam logic [7:0] ADDR_BURST_LAST = 8'h05;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [1:0] FIFO_MODE_OFF = 2'b00;
	// Field layout: 20-bit value occupies bits 23:4 of the 24-bit triple
	localparam int VALUE_LSB = 4;
	localparam int TEMP_LSB = 4;
	// Burst length of a status-plus-results read
	localparam int BURST_BYTES = 6;
	// Entries of the decoded byte map, addresses 00h to 0Fh
	localparam int MAP_DEPTH = 16;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_BURST = 2'b01
	} read_state_t;
endpackage : result_regs_pkg

// file: src/measurement_result_registers.sv
// Read-only measurement result and delta register bank
//
// Functional notes
// - Altimeter select picks altitude or pressure
// - Altitude signed Q16.4 in result bytes
// - Pressure unsigned Q18.2 in result bytes
// - Raw mode fills all 24 pressure bits
// - Auto-increment 00h to 05h burst reads
// - Temperature signed Q8.4 at 04h/05h
// - Raw temperature fills all 16 bits
// - Delta registers hold sample-to-sample difference
// - Altitude delta signed Q16.4 layout
// - Pressure delta unsigned Q18.2 layout
// - Raw mode freezes delta registers
// - Deltas update regardless of FIFO mode
// - FIFO mode: 01h FIFO, 02h-05h zero
`timescale 1ns/1ps
module measurement_result_registers (
	input wire logic mclk_i,
	input wire logic rst_i,
	// Controls from the configuration registers
	input wire logic altimeter_select_i,
	input wire logic raw_select_i,
	input wire logic [1:0] fifo_mode_i,
	// Acquisition results from the converter (same clock)
	input wire logic pressure_strobe_i,
	input wire logic [19:0] pressure_altitude_value_i,
	input wire logic [23:0] pressure_raw_i,
	input wire logic temperature_strobe_i,
	input wire logic [11:0] temperature_value_i,
	input wire logic [15:0] temperature_raw_i,
	// Byte sources for other addresses of the map
	input wire logic [7:0] data_ready_flags_i,
	input wire logic [7:0] fifo_data_i,
	// Register port of the serial slave
	input wire logic rd_start_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic rd_next_i,
	output logic [7:0] rd_data_o,
	output logic [7:0] rd_addr_o,
	output logic fifo_pop_o
);
	import result_regs_pkg::*;

	// Captured result bytes, laid out as read
	logic [23:0] press_reg;
	logic [15:0] temp_reg;

	// Captured delta bytes
	logic [23:0] change_reg;

	// Previous converted sample and the mode it was taken in
	logic [19:0] prev_reg;
	logic prev_valid_reg;
	logic prev_alt_reg;

	// Read pointer and its next value
	logic [7:0] addr_reg;
	logic [7:0] addr_next;

	// Next values of the registered outputs
	logic [7:0] rd_data_next;
	logic fifo_pop_next;

	// Decoded controls
	logic fifo_on;
	logic take_byte;
	logic press_load;
	logic temp_load;
	logic delta_load;
	logic delta_allowed;

	// Assembled fields ready for capture
	logic [23:0] press_conv;
	logic [23:0] press_next;
	logic [15:0] temp_conv;
	logic [15:0] temp_next;
	logic [19:0] diff;
	logic [23:0] change_conv;

	// Byte map of the low part of the address space
	logic [7:0] map_byte [MAP_DEPTH];
	logic [MAP_DEPTH-1:0] entry_hit;

	// Fifo output mode decode
	// fifo mode enable
	assign fifo_on = (fifo_mode_i != FIFO_MODE_OFF);

	// A byte is taken on a pointer load or an advance
	assign take_byte = rd_start_i || rd_next_i;

	// Capture strobes
	assign press_load = pressure_strobe_i;
	assign temp_load = temperature_strobe_i;

	// Converted pressure or altitude in bits 23:4
	// value above reserved nibble
	assign press_conv = {pressure_altitude_value_i, {VALUE_LSB{1'b0}}};

	// Converted temperature in bits 15:4
	// value above reserved nibble
	assign temp_conv = {temperature_value_i, {TEMP_LSB{1'b0}}};

	// Raw or converted pressure source
	always_comb begin
		press_next = press_conv;
		if (raw_select_i) begin
			press_next = pressure_raw_i;
		end
	end

	// Raw or converted temperature source
	always_comb begin
		temp_next = temp_conv;
		if (raw_select_i) begin
			temp_next = temperature_raw_i;
		end
	end

	// Difference against the previous converted sample, 20-bit wrap
	// current minus previous
	assign diff = pressure_altitude_value_i - prev_reg;

	// Delta laid out like the result triple
	// same layout as results
	assign change_conv = {diff, {VALUE_LSB{1'b0}}};

	// Delta only between two converted samples of one mode
	assign delta_allowed = prev_valid_reg && (prev_alt_reg == altimeter_select_i);

	assign delta_load = pressure_strobe_i && !raw_select_i && delta_allowed;

	// Pressure or altitude result capture
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			press_reg <= {3{RESULT_RESET}};
		end else if (press_load) begin
			press_reg <= press_next;
		end
	end

	// Temperature result capture
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			temp_reg <= {2{RESULT_RESET}};
		end else if (temp_load) begin
			temp_reg <= temp_next;
		end
	end

	// Previous sample tracking; a raw sample breaks the chain
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_reg <= '0;
			prev_valid_reg <= 1'b0;
			prev_alt_reg <= 1'b0;
		end else if (pressure_strobe_i) begin
			if (raw_select_i) begin
				prev_valid_reg <= 1'b0;
			end else begin
				prev_reg <= pressure_altitude_value_i;
				prev_valid_reg <= 1'b1;
				prev_alt_reg <= altimeter_select_i;
			end
		end
	end

	// Delta register update
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			change_reg <= {3{RESULT_RESET}};
		end else if (delta_load) begin
			change_reg <= change_conv;
		end
	end

	// Address pointer with auto-increment, wraps at FFh
	always_comb begin
		addr_next = addr_reg;
		if (rd_start_i) begin
			addr_next = rd_addr_i;
		end else if (rd_next_i) begin
			addr_next = addr_reg + 8'h01;
		end
	end

	// Pointer register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_reg <= ADDR_STATUS;
		end else begin
			addr_reg <= addr_next;
		end
	end

	// Byte map: each entry decodes its own address
	for (genvar g = 0; g < MAP_DEPTH; g++) begin : gen_map
		localparam logic [7:0] ENTRY_ADDR = 8'(g);

		// Entry selected by the next pointer value
		assign entry_hit[g] = (addr_next == ENTRY_ADDR);

		// Contents of this entry
		always_comb begin
			map_byte[g] = RESULT_RESET;
			case (ENTRY_ADDR)
				ADDR_STATUS: begin
					map_byte[g] = data_ready_flags_i;
				end

				// fifo data shares the first result address
				ADDR_PRESS_HIGH: begin
					if (fifo_on) begin
						map_byte[g] = fifo_data_i;
					end else begin
						map_byte[g] = press_reg[23:16];
					end
				end

				ADDR_PRESS_MID: begin
					if (fifo_on) begin
						map_byte[g] = RESULT_RESET;
					end else begin
						map_byte[g] = press_reg[15:8];
					end
				end

				ADDR_PRESS_LOW: begin
					if (fifo_on) begin
						map_byte[g] = RESULT_RESET;
					end else begin
						map_byte[g] = press_reg[7:0];
					end
				end

				ADDR_TEMP_HIGH: begin
					if (fifo_on) begin
						map_byte[g] = RESULT_RESET;
					end else begin
						map_byte[g] = temp_reg[15:8];
					end
				end

				ADDR_TEMP_LOW: begin
					if (fifo_on) begin
						map_byte[g] = RESULT_RESET;
					end else begin
						map_byte[g] = temp_reg[7:0];
					end
				end

				// deltas readable in any fifo mode
				ADDR_CHANGE_HIGH: begin
					map_byte[g] = change_reg[23:16];
				end

				ADDR_CHANGE_MID: begin
					map_byte[g] = change_reg[15:8];
				end

				ADDR_CHANGE_LOW: begin
					map_byte[g] = change_reg[7:0];
				end

				default: begin
					map_byte[g] = RESULT_RESET;
				end
			endcase
		end
	end : gen_map

	// Select the addressed byte; beyond the map reads zero
	always_comb begin
		rd_data_next = RESULT_RESET;
		for (int k = 0; k < MAP_DEPTH; k++) begin
			if (entry_hit[k]) begin
				rd_data_next = map_byte[k];
			end
		end
	end

	// pop on each fifo byte taken
	assign fifo_pop_next = take_byte && (addr_next == ADDR_PRESS_HIGH) && fifo_on;

	// Registered read data, resampled every cycle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= RESULT_RESET;
		end else begin
			rd_data_o <= rd_data_next;
		end
	end

	// Registered pointer copy
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// Pointer starts at the status byte
			rd_addr_o <= ADDR_STATUS;
		end else begin
			rd_addr_o <= addr_next;
		end
	end

	// Registered fifo pop pulse, one cycle per byte
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// No pop while in reset
			fifo_pop_o <= 1'b0;
		end else begin
			fifo_pop_o <= fifo_pop_next;
		end
	end

endmodule : measurement_result_registers

// file: testbench/result_regs_checker.sv
// Checker of the result register read port
`timescale 1ns/1ps
module result_regs_checker (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic rd_start_i,
	input wire logic rd_next_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic [1:0] fifo_mode_i,
	input wire logic [7:0] rd_data_o,
	input wire logic [7:0] rd_addr_o,
	input wire logic fifo_pop_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Pointer moves and byte contents
	property p_ld; rd_start_i |=> rd_addr_o==$past(rd_addr_i); endproperty
	a_ld: assert property (p_ld) else $error("load");
	property p_inc; !rd_start_i&&rd_next_i |=> rd_addr_o==8'($past(rd_addr_o)+1); endproperty
	a_inc: assert property (p_inc) else $error("incr");
	property p_hld; !rd_start_i&&!rd_next_i |=> $stable(rd_addr_o); endproperty
	a_hld: assert property (p_hld) else $error("hold");
	property p_fz; rd_addr_o inside {[8'h02:8'h05]}&&$past(fifo_mode_i)!=2'h0 |-> !rd_data_o; endproperty
	a_fz: assert property (p_fz) else $error("fifo zero");
	property p_un; rd_addr_o==8'h06||rd_addr_o>8'h09 |-> rd_data_o==8'h00; endproperty
	a_un: assert property (p_un) else $error("unmapped");
	property p_lo; rd_addr_o==8'h09 |-> rd_data_o[3:0]==4'h0; endproperty
	a_lo: assert property (p_lo) else $error("low bits");
	property p_pop; fifo_pop_o |-> rd_addr_o==8'h01&&$past(fifo_mode_i)!=2'h0; endproperty
	a_pop: assert property (p_pop) else $error("pop");
	property p_pld; rd_next_i&&!rd_start_i&&rd_addr_o==8'h00&&fifo_mode_i!=2'h0 |=> fifo_pop_o; endproperty
	a_pld: assert property (p_pld) else $error("no pop");
endmodule : result_regs_checker
bind measurement_result_registers result_regs_checker i_result_regs_checker (.mclk_i, .rst_i,
	.rd_start_i, .rd_next_i, .rd_addr_i, .fifo_mode_i, .rd_data_o, .rd_addr_o, .fifo_pop_o);

// file: testbench/serial_host.sv
// Host model issuing burst reads on the register port
`timescale 1ns/1ps
module serial_host (
	input wire logic mclk_i,
	input wire logic [7:0] rd_data_i,
	output logic rd_start_o = 1'h0,
	output logic [7:0] rd_addr_o = 8'h00,
	output logic rd_next_o = 1'h0
);
	logic [7:0] got [10];
	task rd;
		@(negedge mclk_i);
		rd_start_o = 1'h1;
		rd_addr_o = 8'h00;
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk_i);
			rd_start_o = 1'h0;
			rd_addr_o = ~rd_addr_o; // Released address toggles
			rd_next_o = i < 9;
			got[i] = rd_data_i;
		end
	endtask : rd
endmodule : serial_host

// file: testbench/measurement_result_registers_tb_top.sv
// Testbench of the measurement result register bank
`timescale 1ns/1ps
module measurement_result_registers_tb_top;
	logic mclk_i = 0, rst_i = 1, a = 0, r = 0, s = 0, rd_start_i, rd_next_i, fifo_pop_o;
	logic [1:0] fifo_mode_i = 2'h0;
	logic [23:0] w = 24'h0;
	logic [15:0] u = 16'h0;
	logic [7:0] rd_addr_i, rd_data_o, rd_addr_o, data_ready_flags_i = 8'ha5, fifo_data_i = 8'h5c;
	int n_mismatch = 0, n_tests = 0, n_pop = 0;
	measurement_result_registers i_measurement_result_registers (.*, .altimeter_select_i(a),
		.raw_select_i(r), .pressure_strobe_i(s), .temperature_strobe_i(s), .pressure_raw_i(w),
		.pressure_altitude_value_i(w[19:0]), .temperature_value_i(u[11:0]), .temperature_raw_i(u));
	serial_host i_serial_host (.mclk_i, .rd_data_i(rd_data_o), .rd_start_o(rd_start_i),
		.rd_addr_o(rd_addr_i), .rd_next_o(rd_next_i));
	// Free-running clock
	initial forever #50 mclk_i = ~mclk_i;
	// Count fifo pops where the pulse has settled
	always @(negedge mclk_i) if (fifo_pop_o === 1'b1) n_pop++;
	// Byte compare
	task cmp8(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_tests++;
		if (got !== ex) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, ex, got);
		end
	endtask : cmp8
	// One sample strobe for both results
	task smp(input logic sa, sr, input logic [23:0] sw, input logic [15:0] su);
		@(negedge mclk_i);
		a = sa;
		r = sr;
		w = sw;
		u = su;
		s = 1'h1;
		@(negedge mclk_i);
		s = 1'h0;
	endtask : smp
	// Burst read 00h to 09h and compare
	task chk(input logic [79:0] e, input logic [7:0] np);
		n_pop = 0;
		i_serial_host.rd();
		for (int i = 0; i < 10; i++) begin
			cmp8("burst byte", e[79-8*i-:8], i_serial_host.got[i]);
		end
		cmp8("pointer", 8'h09, rd_addr_o);
		cmp8("fifo pops", np, 8'(n_pop));
	endtask : chk
	task conclude;
		$display("mismatches %0d compares %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	// Main sequence
	initial begin
		repeat (20) @(negedge mclk_i);
		rst_i = 0;
		chk(80'ha5000000000000000000, 8'h00);
		smp(1'h0, 1'h0, 24'h12345, 16'hab3);
		smp(1'h0, 1'h0, 24'h12445, 16'hab3);
		chk(80'ha5124450ab3000001000, 8'h00);
		fifo_mode_i = 2'h1;
		smp(1'h1, 1'h0, 24'hfff10, 16'hab3);
		smp(1'h1, 1'h0, 24'hfff30, 16'hab3);
		chk(80'ha55c0000000000000200, 8'h01);
		fifo_mode_i = 2'h0;
		chk(80'ha5fff300ab3000000200, 8'h00);
		smp(1'h1, 1'h1, 24'h9abcde, 16'h1357);
		chk(80'ha59abcde135700000200, 8'h00);
		conclude();
	end
endmodule : measurement_result_registers_tb_top
